// >>> asr_consts.vh
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH

// Register byte offsets
`define ASR_OFF_CMD        8'h00
`define ASR_OFF_DECIM      8'h04
`define ASR_OFF_RESULT     8'h08
`define ASR_OFF_STATUS     8'h0C

// Command register fields
`define ASR_CMD_SYNC_BIT   0
`define ASR_CMD_RST        8'h00

// Status register fields
`define ASR_ST_MASTER_BIT  0
`define ASR_ST_BUSY_BIT    1
`define ASR_ST_WDOG_BIT    2
`define ASR_ST_DONE_N_BIT  3

// Conversion period in master clocks
`define ASR_DECIM_RST      16'h0100

// Serial framing
`define ASR_INSTR_BITS     6'h08
`define ASR_WDATA_BITS     6'h10
`define ASR_RDATA_BITS     6'h20
`define ASR_INSTR_RD_BIT   7

// Stall limit in conversion periods
`define ASR_WDOG_PERIODS   3'h4

`endif

// >>> asr_conv_timer.v
`timescale 1ns/1ps
module asr_conv_timer #(
    parameter CW = 16
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire [CW-1:0] period_i,
    input  wire          sync_i,
    output reg           period_end_o,
    output reg           done_n_o
);
    reg [CW-1:0] count_r;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_r      <= {CW{1'b0}};
            period_end_o <= 1'b0;
            done_n_o     <= 1'b1;
        end
        else if (sync_i)
        begin
            // Stored results stay; only the running count restarts
            count_r      <= {CW{1'b0}}; // [R9]
            period_end_o <= 1'b0;
        end
        else if (count_r >= period_i - {{(CW-1){1'b0}}, 1'b1})
        begin
            count_r      <= {CW{1'b0}};
            period_end_o <= 1'b1;
            done_n_o     <= 1'b0; // [R10]
        end
        else
        begin
            count_r      <= count_r + {{(CW-1){1'b0}}, 1'b1};
            period_end_o <= 1'b0;
            // Forced high just before the output register updates
            if (count_r == period_i - {{(CW-2){1'b0}}, 2'b10})
                done_n_o <= 1'b1;
        end
    end
endmodule // asr_conv_timer

// >>> asr_serial_ctrl.v
// Function
// [R1] Host changes the master/slave input only between serial transfers.
// [R2] Changing master/slave mode leaves the held conversion result untouched.
// [R3] A transfer stalled over four conversion periods resets the serial state machine.
// [R4] That stall reset leaves configuration and data registers unchanged.
// [R5] After a stall reset the host restarts the transfer from its first byte.
// [R6] A freshly reset host idles eight conversion periods before talking.
// [R7] Serial data output is high impedance except while result bits shift out.
// [R8] Synced converters share decimation, speed setting and one master clock.
// [R9] A low pulse on the sync input zeroes the running modulator count.
// [R10] After sync all matched converters count from zero and flag done together.
// [R11] An unaligned sync pulse may offset converters by one master clock.
// [R12] Selection high: device makes serial clock; low: it takes the host clock.
// [R13] Writing the command sync bit zeroes the modulator count like the pin.
// [R14] Stall counter counts periods, clears on each serial edge, armed mid-transfer.
`timescale 1ns/1ps
`include "asr_consts.vh"
module asr_serial_ctrl #(
    parameter CW = 16
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg         wb_ack_o,
    output reg  [31:0] wb_dat_o,
    input  wire        mode_master_i,
    input  wire        modulator_sync_n_i,
    input  wire        sclk_i,
    output reg         sclk_o,
    output reg         sclk_oe_o,
    input  wire        sdio_i,
    output reg         serial_out_pin_o,
    output reg         serial_out_pin_oe_o,
    input  wire [23:0] conv_result_i,
    output reg         conversion_done_n_o
);
    localparam ST_IDLE  = 2'b00;
    localparam ST_INSTR = 2'b01;
    localparam ST_WDATA = 2'b10;
    localparam ST_RDATA = 2'b11;

    reg  [1:0]    mode_s_r;
    reg  [1:0]    sync_s_r;
    reg           sync_d_r;
    reg  [2:0]    sclk_s_r;
    reg  [1:0]    sdio_s_r;
    reg           master_r;
    reg           run_r;
    reg           int_clk_r;
    reg  [1:0]    state_r;
    reg  [1:0]    state_nxt;
    reg  [5:0]    bit_cnt_r;
    reg  [23:0]   shift_r;
    reg  [7:0]    cmd_r;
    reg  [CW-1:0] decim_r;
    reg  [23:0]   result_r;
    reg  [2:0]    wdog_cnt_r;
    reg           wdog_flag_r;
    reg           sync_pulse_r;

    wire          period_end;
    wire          done_n;
    wire          wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire          wb_wr      = wb_req & wb_we_i;
    wire          rise       = master_r ? (run_r & ~int_clk_r) : (sclk_s_r[1] & ~sclk_s_r[2]);
    wire          fall       = master_r ? (run_r & int_clk_r) : (~sclk_s_r[1] & sclk_s_r[2]);
    wire          mid_xfer   = (state_r != ST_IDLE);
    wire          wdog_fire  = mid_xfer & period_end & ~(rise | fall)
                               & (wdog_cnt_r == `ASR_WDOG_PERIODS);
    wire          pin_sync   = ~sync_s_r[1] & sync_d_r;
    wire          bit_in     = sdio_s_r[1];
    wire          instr_done = rise & (state_r == ST_INSTR)
                               & (bit_cnt_r == `ASR_INSTR_BITS - 6'h01);
    wire          wdata_done = rise & (state_r == ST_WDATA)
                               & (bit_cnt_r == `ASR_WDATA_BITS - 6'h01);
    wire          rdata_done = fall & (state_r == ST_RDATA)
                               & (bit_cnt_r == `ASR_RDATA_BITS);
    wire          wb_cmd_wr  = wb_wr & wb_sel_i[0] & (wb_adr_i == `ASR_OFF_CMD);

    asr_conv_timer #(
        .CW (CW)
    ) u_timer (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .period_i     (decim_r),
        .sync_i       (sync_pulse_r),
        .period_end_o (period_end),
        .done_n_o     (done_n)
    );

    // Input synchronisers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_s_r <= 2'b00;
            sync_s_r <= 2'b11;
            sync_d_r <= 1'b1;
            sclk_s_r <= 3'b000;
            sdio_s_r <= 2'b00;
        end
        else
        begin
            mode_s_r <= {mode_s_r[0], mode_master_i};
            // Two stages on an unaligned pulse cost up to one clock of skew
            sync_s_r <= {sync_s_r[0], modulator_sync_n_i}; // [R11]
            sync_d_r <= sync_s_r[1];
            sclk_s_r <= {sclk_s_r[1:0], sclk_i};
            sdio_s_r <= {sdio_s_r[0], sdio_i};
        end
    end

    // Sync requests from pin, bus or serial command write
    always @(posedge clk_i)
    begin
        if (rst_i)
            sync_pulse_r <= 1'b0;
        else
            // The last serial bit in is the command's sync bit
            sync_pulse_r <= pin_sync // [R9]
                | (wb_cmd_wr & wb_dat_i[`ASR_CMD_SYNC_BIT]) // [R13]
                | (wdata_done & bit_in); // [R13]
    end

    // Mode is taken only while the port is idle, so a stray change cannot cut a frame
    always @(posedge clk_i)
    begin
        if (rst_i)
            master_r <= 1'b0;
        else if (~mid_xfer & ~run_r)
            master_r <= mode_s_r[1]; // [R1] [R12]
    end

    // Serial clock generation at half the master clock rate
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run_r     <= 1'b0;
            int_clk_r <= 1'b0;
        end
        else
        begin
            if (~master_r | rdata_done | wdata_done | wdog_fire)
                run_r <= 1'b0;
            else if (period_end & ~mid_xfer)
                run_r <= 1'b1; // [R12]
            if (run_r)
                int_clk_r <= ~int_clk_r;
            else
                int_clk_r <= 1'b0;
        end
    end

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (rise)
                    state_nxt = ST_INSTR;
            ST_INSTR:
                if (instr_done)
                    state_nxt = shift_r[`ASR_INSTR_RD_BIT - 1] ? ST_RDATA : ST_WDATA;
            ST_WDATA:
                if (wdata_done)
                    state_nxt = ST_IDLE;
            ST_RDATA:
                if (rdata_done)
                    state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
        if (wdog_fire)
            state_nxt = ST_IDLE; // [R3] [R5]
    end

    // Serial state machine; a stall reset touches this group and run_r
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r             <= ST_IDLE;
            bit_cnt_r           <= 6'h00;
            shift_r             <= 24'h000000;
            serial_out_pin_o    <= 1'b0;
            serial_out_pin_oe_o <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (wdog_fire)
            begin
                bit_cnt_r           <= 6'h00; // [R3] [R4]
                serial_out_pin_oe_o <= 1'b0;
            end
            else
            begin
                if (rise & (state_r != ST_RDATA))
                begin
                    shift_r   <= {shift_r[22:0], bit_in};
                    bit_cnt_r <= bit_cnt_r + 6'h01;
                end
                if (instr_done & shift_r[`ASR_INSTR_RD_BIT - 1])
                    shift_r <= result_r; // [R2]
                if (fall & (state_r == ST_RDATA) & ~rdata_done)
                begin
                    serial_out_pin_o    <= shift_r[23];
                    serial_out_pin_oe_o <= 1'b1; // [R7]
                    shift_r             <= {shift_r[22:0], 1'b0};
                    bit_cnt_r           <= bit_cnt_r + 6'h01;
                end
                if (rdata_done | wdata_done)
                begin
                    bit_cnt_r           <= 6'h00;
                    serial_out_pin_oe_o <= 1'b0; // [R7]
                end
            end
        end
    end

    // Stall watchdog in conversion periods
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wdog_cnt_r  <= 3'h0;
            wdog_flag_r <= 1'b0;
        end
        else
        begin
            if (rise | fall | ~mid_xfer)
                wdog_cnt_r <= 3'h0; // [R14]
            else if (period_end)
                wdog_cnt_r <= wdog_cnt_r + 3'h1; // [R14]
            if (wdog_fire)
                wdog_flag_r <= 1'b1;
            else if (wb_wr & wb_sel_i[0] & (wb_adr_i == `ASR_OFF_STATUS)
                     & wb_dat_i[`ASR_ST_WDOG_BIT])
                wdog_flag_r <= 1'b0;
        end
    end

    // Registers; untouched by the serial stall reset
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd_r    <= `ASR_CMD_RST;
            decim_r  <= `ASR_DECIM_RST;
            result_r <= 24'h000000;
        end
        else
        begin
            if (period_end)
                result_r <= conv_result_i; // [R2]
            if (wb_cmd_wr)
                cmd_r <= wb_dat_i[7:0];
            else if (wdata_done)
                cmd_r <= {shift_r[6:0], bit_in}; // [R4]
            if (wb_wr & (wb_adr_i == `ASR_OFF_DECIM))
            begin
                if (wb_sel_i[0])
                    decim_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    decim_r[CW-1:8] <= wb_dat_i[CW-1:8];
            end
        end
    end

    // Wishbone slave: ack one cycle after the request, dropped the next cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req & ~wb_we_i)
            begin
                case (wb_adr_i)
                    `ASR_OFF_CMD:
                        wb_dat_o <= {24'h000000, cmd_r};
                    `ASR_OFF_DECIM:
                        wb_dat_o <= {{(32-CW){1'b0}}, decim_r};
                    `ASR_OFF_RESULT:
                        wb_dat_o <= {8'h00, result_r};
                    `ASR_OFF_STATUS:
                        wb_dat_o <= {28'h0000000, done_n, wdog_flag_r, mid_xfer, master_r};
                    default:
                        wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Registered pin outputs
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sclk_o              <= 1'b0;
            sclk_oe_o           <= 1'b0;
            conversion_done_n_o <= 1'b1;
        end
        else
        begin
            sclk_o              <= int_clk_r;
            sclk_oe_o           <= master_r; // [R12]
            conversion_done_n_o <= done_n; // [R10]
        end
    end
endmodule // asr_serial_ctrl

// >>> asr_serial_ctrl_asserts.sv
`timescale 1ns/1ps
module asr_serial_ctrl_chk (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_ack_o,
    input wire [31:0] wb_dat_o,
    input wire        mode_master_i,
    input wire        modulator_sync_n_i,
    input wire        sclk_o,
    input wire        sclk_oe_o,
    input wire        serial_out_pin_oe_o,
    input wire        conversion_done_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Sync edge has had time to cross the synchroniser
    sequence sync_fell;
        $fell(modulator_sync_n_i) ##5 1'b1;
    endsequence
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_timely_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    reset_idle_a: assert property (disable iff (1'b0)
        rst_i |=> !sclk_oe_o && !serial_out_pin_oe_o && conversion_done_n_o)
        else $error("pins driven in reset");
    mode_master_a: assert property ($rose(sclk_oe_o) |-> $past(mode_master_i, 2)
        || $past(mode_master_i, 3) || $past(mode_master_i, 4))
        else $error("serial clock driven in slave mode");
    sclk_half_a: assert property ($rose(sclk_o) |=> $fell(sclk_o))
        else $error("serial clock not half rate");
    sync_clears_a: assert property (sync_fell |-> (!$rose(conversion_done_n_o))[*8])
        else $error("done after sync too soon");
    done_pulse_a: assert property ($rose(conversion_done_n_o) |-> ##[1:3] !conversion_done_n_o)
        else $error("done flag stuck high");
endmodule // asr_serial_ctrl_chk
bind asr_serial_ctrl asr_serial_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .mode_master_i(mode_master_i), .modulator_sync_n_i(modulator_sync_n_i),
    .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .serial_out_pin_oe_o(serial_out_pin_oe_o),
    .conversion_done_n_o(conversion_done_n_o));

// >>> asr_host_model.sv
`timescale 1ns/1ps
module asr_host_model (
    input  wire  serial_out_pin_i,
    output logic sclk_o,
    output logic sdio_o
);
    initial
    begin
        sclk_o = 1'b0;
        sdio_o = 1'b0;
    end
    // Link clock 160 ns, still between frames; tx sent MSB first from bit 15
    task automatic frame(input logic [15:0] tx, input int n_tx, input int n_rx,
                         output logic [23:0] rx);
        int i;
        rx = 24'h0;
        #7;
        for (i = 0; i < n_tx + n_rx; i++)
        begin
            // Released line toggles so a stale bit is never mistaken for data
            sdio_o = (i < n_tx) ? tx[15 - i] : ~sdio_o;
            #80 sclk_o = 1'b1;
            if (i >= n_tx)
                rx = {rx[22:0], serial_out_pin_i};
            #80 sclk_o = 1'b0;
        end
        sdio_o = ~sdio_o;
    endtask
endmodule // asr_host_model

// >>> adc_serial_recovery_sync_test.sv
`timescale 1ns/1ps
`include "asr_consts.vh"
module adc_serial_recovery_sync_test;
    localparam int PER = 16;
    logic [7:0]  adr;
    logic [31:0] wdat, r;
    logic [23:0] res, rx;
    logic [3:0]  sel;
    logic        clk_i, rst_i, we, cyc, stb, mode, sync_n, p;
    wire         ack, sck, sck_oe, so, so_oe, done_n, h_sck, h_sd;
    wire  [31:0] rdat;
    wire         sck_w = sck_oe ? sck : h_sck;
    // Undriven data pin reads inverted so a stale bit cannot pass as data
    wire         so_w  = so_oe ? so : ~so;
    int          mismatches, total_checks, n;
    asr_serial_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .wb_dat_o(rdat), .mode_master_i(mode), .modulator_sync_n_i(sync_n),
        .sclk_i(sck_w), .sclk_o(sck), .sclk_oe_o(sck_oe), .sdio_i(h_sd),
        .serial_out_pin_o(so), .serial_out_pin_oe_o(so_oe), .conv_result_i(res),
        .conversion_done_n_o(done_n));
    asr_host_model host (.serial_out_pin_i(so_w), .sclk_o(h_sck), .sdio_o(h_sd));
    task automatic give_verdict;
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Second request lands mid-period, so only a real restart gives a full period
    task automatic sync_gap(input logic by_pin);
        // Start just after a period end so no sync lands on a raised done flag
        do
        begin
            p = done_n;
            @(posedge clk_i);
        end
        while (!(p === 1'b1 && done_n === 1'b0));
        for (int i = 0; i < 2; i++)
        begin
            if (by_pin)
            begin
                @(posedge clk_i);
                sync_n <= 1'b0;
                @(posedge clk_i);
                sync_n <= 1'b1;
            end
            else
                wb(1'b1, `ASR_OFF_CMD, 32'h1);
            if (i == 0)
                repeat (10) @(posedge clk_i);
        end
        n = 0;
        do
        begin
            p = done_n;
            @(posedge clk_i);
            n++;
        end
        while (!(p === 1'b0 && done_n === 1'b1));
        check("sync gap", 32'h1, {31'h0, n >= PER - 2 && n <= PER + 6});
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial
    begin
        #200000;
        mismatches++;
        give_verdict;
    end
    initial
    begin
        {rst_i, cyc, stb, we, adr, wdat, sel, mode} = {1'b1, 48'h0};
        sync_n = 1'b1;
        res = 24'hA5C396;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        wb(1'b0, `ASR_OFF_DECIM, 32'h0);
        check("decim", {16'h0, `ASR_DECIM_RST}, r);
        wb(1'b0, 8'h10, 32'h0);
        check("unmapped", 32'h0, r);
        wb(1'b1, `ASR_OFF_DECIM, PER);
        repeat (8 * PER) @(posedge clk_i);
        host.frame(16'h8000, 8, 24, rx);
        check("read", res, rx);
        repeat (8) @(posedge clk_i);
        check("out oe", 32'h0, so_oe);
        host.frame(16'h8000, 4, 0, rx);
        repeat (2 * PER) @(posedge clk_i);
        host.frame(16'h0000, 4, 24, rx);
        check("slow read", res, rx);
        wb(1'b0, `ASR_OFF_STATUS, 32'h0);
        check("no stall", 32'h0, r[`ASR_ST_WDOG_BIT]);
        host.frame(16'h8000, 4, 0, rx);
        repeat (6 * PER) @(posedge clk_i);
        wb(1'b0, `ASR_OFF_STATUS, 32'h0);
        check("stall", 32'h1, r[`ASR_ST_WDOG_BIT]);
        wb(1'b0, `ASR_OFF_DECIM, 32'h0);
        check("kept decim", PER, r);
        wb(1'b1, `ASR_OFF_STATUS, 32'h4);
        wb(1'b0, `ASR_OFF_STATUS, 32'h0);
        check("stall clear", 32'h0, r[`ASR_ST_WDOG_BIT]);
        host.frame(16'h8000, 8, 24, rx);
        check("restart", res, rx);
        @(posedge clk_i);
        mode <= 1'b1;
        repeat (40) @(posedge clk_i);
        wb(1'b0, `ASR_OFF_STATUS, 32'h0);
        check("master", 32'h1, r[`ASR_ST_MASTER_BIT]);
        check("sclk oe", 32'h1, sck_oe);
        repeat (300) @(posedge clk_i);
        // Wait for an idle port so the mode pin does not move mid-frame
        do
            wb(1'b0, `ASR_OFF_STATUS, 32'h0);
        while (r[`ASR_ST_BUSY_BIT] !== 1'b0);
        mode <= 1'b0;
        repeat (300) @(posedge clk_i);
        wb(1'b0, `ASR_OFF_RESULT, 32'h0);
        check("result", {8'h0, res}, r);
        check("slave oe", 32'h0, sck_oe);
        host.frame(16'h8000, 8, 24, rx);
        check("slave read", res, rx);
        sync_gap(1'b1);
        sync_gap(1'b0);
        give_verdict;
    end
endmodule // adc_serial_recovery_sync_test
